/* File: core/burst2_sram_regs.svh */
// Constants for the burst-of-two common-I/O SRAM device model
`ifndef BURST2_SRAM_REGS_SVH
`define BURST2_SRAM_REGS_SVH

`define ADDR_W         19
`define DATA_W         36
`define LANES          4
`define LANE_W         9
`define PIPE_N         8
`define LAT_DLL        3'h5
`define LAT_BYP        3'h2
`define CLK_PERIOD_NS  10
`define T_KSTOP_NS     30
`define KSTOP_CYC      ((`T_KSTOP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define KSTOP_W        4
`define LOCK_CYC       12'h800
`define LOCK_W         12
`define ZQ_CYC         11'h400
`define ZQ_CNT_W       11
`define ZQ_W           6
`define ZQ_MID         6'h20

`endif

/* File: core/burst2_sram_pkg.sv */
// Types shared by the burst-of-two common-I/O SRAM device model
`include "burst2_sram_regs.svh"
package burst2_sram_pkg;
    typedef struct packed {
        logic                 k;
        logic                 k_n;
        logic                 load_strobe_n;
        logic                 rw;
        logic [`ADDR_W-1:0]   addr;
        logic [`DATA_W-1:0]   dq;
        logic [`LANES-1:0]    byte_write_mask_n;
        logic                 dll_bypass_n;
        logic [`ZQ_W-1:0]     impedance_ref_pin;
    } pins_s;

    typedef struct packed {
        logic                 valid;
        logic [`ADDR_W-1:0]   addr;
    } rd_stage_s;

    typedef struct packed {
        logic [`ADDR_W-1:0]   addr;
        logic [`DATA_W-1:0]   d0;
        logic [`DATA_W-1:0]   d1;
        logic [`LANES-1:0]    m0_n;
        logic [`LANES-1:0]    m1_n;
    } wbuf_s;
endpackage : burst2_sram_pkg

/* File: core/burst2_common_io_sram.sv */
// Burst-of-two DDR common-I/O SRAM device logic, sampled on a fast system clock
//
// Function
// - Read starts when direction is high and load strobe low at a K rise.
// - First read beat is driven 2.5 cycles after the read, on a K# rise, with the DLL on.
// - Second read beat is driven 3 cycles after the read, on a K rise, with the DLL on.
// - Free-running echo clock pair follows the data output timing.
// - Address is captured at a K rise only while load strobe is low.
// - Load strobe high is a NOP; running reads finish, then drivers release.
// - Write starts at a K rise with direction low and load strobe low.
// - Write beats arrive one K cycle after command, then on the next K#.
// - Buffered write data is committed to the array on the third write.
// - Reads hitting the two latest write addresses return buffered data.
// - Each byte mask independently gates its byte on each burst beat.
// - Direction high at K rise never modifies memory contents.
// - Driver impedance starts mid-range, final within 1024 cycles.
// - Read-valid flag rises half a cycle before first, falls before last beat.
// - Bypass input low selects the 1.0 cycle read latency.
// - DLL resets on bypass low-to-high or both clocks static 30 ns.
// - DLL reports lock after 2048 stable K cycles following a reset.
// - Data-pin termination is on while receiving, off while driving reads.
// - Clock and byte-mask termination stays permanently enabled.
// - Termination off at read+RL-0.5, back on at last read+RL+1.5.
// - Second burst beat uses captured address plus one.
`timescale 1ns/1ps
`include "burst2_sram_regs.svh"
module burst2_common_io_sram (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 k_i,
    input  wire logic                 k_n_i,
    input  wire logic                 load_strobe_n_i,
    input  wire logic                 rw_i,
    input  wire logic [`ADDR_W-1:0]   addr_i,
    input  wire logic [`DATA_W-1:0]   dq_i,
    output logic      [`DATA_W-1:0]   dq_o,
    output logic                      dq_oe_n_o,
    input  wire logic [`LANES-1:0]    byte_write_mask_n_i,
    input  wire logic                 dll_bypass_n_i,
    input  wire logic [`ZQ_W-1:0]     impedance_ref_pin_i,
    output logic                      echo_timing_pos_o,
    output logic                      echo_timing_neg_o,
    output logic                      read_valid_flag_o,
    output logic                      odt_data_o,
    output logic                      odt_clk_mask_o,
    output logic                      dll_locked_o,
    output logic      [`ZQ_W-1:0]     impedance_code_o,
    output logic                      impedance_done_o,
    output logic                      write_buf_ready_o
);
    import burst2_sram_pkg::*;

    localparam int DEPTH = 1 << `ADDR_W;

    // Pin synchronisers; third stage only feeds edge detection
    pins_s                    pin_raw;
    pins_s                    sync1_q;
    pins_s                    sync2_q;
    logic                     k_prev_q;
    logic                     kn_prev_q;
    logic                     byp_prev_q;

    assign pin_raw = '{k: k_i, k_n: k_n_i, load_strobe_n: load_strobe_n_i, rw: rw_i,
                       addr: addr_i, dq: dq_i, byte_write_mask_n: byte_write_mask_n_i,
                       dll_bypass_n: dll_bypass_n_i, impedance_ref_pin: impedance_ref_pin_i};

    always_ff @(posedge clk_i) begin
        sync1_q    <= pin_raw;
        sync2_q    <= sync1_q;
        k_prev_q   <= sync2_q.k;
        kn_prev_q  <= sync2_q.k_n;
        byp_prev_q <= sync2_q.dll_bypass_n;
    end

    wire k_rise    = sync2_q.k & ~k_prev_q;
    wire kn_rise   = sync2_q.k_n & ~kn_prev_q;
    wire half_edge = k_rise | kn_rise;
    wire load      = k_rise & ~sync2_q.load_strobe_n;
    wire rd_cmd    = load & sync2_q.rw;
    wire wr_cmd    = load & ~sync2_q.rw;

    // Read latency in half-cycles: 5 with DLL, 2 in bypass
    logic [2:0]               lat_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lat_q <= `LAT_DLL;
        end else begin
            lat_q <= sync2_q.dll_bypass_n ? `LAT_DLL : `LAT_BYP;
        end
    end

    wire [2:0] idx_m2 = lat_q - 3'h2;
    wire [2:0] idx_m1 = lat_q - 3'h1;
    wire [2:0] idx_p1 = lat_q + 3'h1;

    // Half-cycle read pipeline; a NOP only shifts it, never flushes it
    rd_stage_s                pipe_q [`PIPE_N];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < `PIPE_N; i++) begin
                pipe_q[i] <= '0;
            end
        end else if (half_edge) begin
            pipe_q[0] <= '{valid: rd_cmd, addr: sync2_q.addr};
            for (int i = 1; i < `PIPE_N; i++) begin
                pipe_q[i] <= pipe_q[i-1];
            end
        end
    end

    wire beat0_due = pipe_q[idx_m1].valid;
    wire beat1_due = pipe_q[lat_q].valid;
    wire [`ADDR_W-1:0] rd_addr = beat0_due ? pipe_q[idx_m1].addr
                                           : pipe_q[lat_q].addr + `ADDR_W'(1);
    wire odt_off_next = pipe_q[idx_m2].valid | beat0_due | beat1_due
                      | pipe_q[idx_p1].valid;

    // Late-write capture: beat 0 on the next K rise, beat 1 on the next K# rise
    wbuf_s                    wcap_q;
    logic                     wr_b1_q;
    logic                     wr_b2_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_b1_q <= 1'b0;
            wr_b2_q <= 1'b0;
            wcap_q  <= '0;
        end else begin
            if (k_rise) begin
                wr_b1_q <= wr_cmd;
            end
            if (wr_cmd) begin
                wcap_q.addr <= sync2_q.addr;
            end
            if (k_rise && wr_b1_q) begin
                wcap_q.d0   <= sync2_q.dq;
                wcap_q.m0_n <= sync2_q.byte_write_mask_n;
                wr_b2_q     <= 1'b1;
            end else if (kn_rise && wr_b2_q) begin
                wr_b2_q     <= 1'b0;
            end
        end
    end

    wire [`DATA_W-1:0] wcap_d1 = sync2_q.dq;
    wire [`LANES-1:0]  wcap_m1 = sync2_q.byte_write_mask_n;

    // Two-entry write buffer; drained only by a later write command
    wbuf_s                    wbuf_q [2];
    logic                     wptr_q;
    logic                     rptr_q;
    logic [1:0]               wcnt_q;
    wire wbuf_full  = wcnt_q == 2'h2;
    wire wbuf_pop   = wr_cmd & wbuf_full;
    wire wbuf_ready = ~wbuf_full | wbuf_pop;
    wire wbuf_push  = kn_rise & wr_b2_q & wbuf_ready;
    wbuf_s head;
    wbuf_s newest;
    wbuf_s older;
    assign head   = wbuf_q[rptr_q];
    assign newest = wbuf_q[~wptr_q];
    assign older  = wbuf_q[wptr_q];
    wire newest_ok = wcnt_q != 2'h0;
    wire older_ok  = wbuf_full;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wptr_q <= 1'b0;
            rptr_q <= 1'b0;
            wcnt_q <= 2'h0;
        end else begin
            if (wbuf_push) begin
                wbuf_q[wptr_q] <= '{addr: wcap_q.addr, d0: wcap_q.d0, d1: wcap_d1,
                                    m0_n: wcap_q.m0_n, m1_n: wcap_m1};
                wptr_q         <= ~wptr_q;
            end
            if (wbuf_pop) begin
                rptr_q <= ~rptr_q;
            end
            wcnt_q <= wcnt_q + {1'b0, wbuf_push} - {1'b0, wbuf_pop};
        end
    end

    // Per-lane array and coherent read merge
    logic [`DATA_W-1:0]       rd_word;
    wire [`ADDR_W-1:0] head_a1   = head.addr + `ADDR_W'(1);
    wire [`ADDR_W-1:0] newest_a1 = newest.addr + `ADDR_W'(1);
    wire [`ADDR_W-1:0] older_a1  = older.addr + `ADDR_W'(1);

    for (genvar b = 0; b < `LANES; b++) begin : g_lane
        logic [`LANE_W-1:0] lane_mem_q [DEPTH];
        always_ff @(posedge clk_i) begin
            if (wbuf_pop && !head.m0_n[b]) begin
                lane_mem_q[head.addr] <= head.d0[b*`LANE_W +: `LANE_W];
            end
            if (wbuf_pop && !head.m1_n[b]) begin
                lane_mem_q[head_a1] <= head.d1[b*`LANE_W +: `LANE_W];
            end
        end
        wire n0 = newest_ok & (newest.addr == rd_addr) & ~newest.m0_n[b];
        wire n1 = newest_ok & (newest_a1 == rd_addr) & ~newest.m1_n[b];
        wire o0 = older_ok & (older.addr == rd_addr) & ~older.m0_n[b];
        wire o1 = older_ok & (older_a1 == rd_addr) & ~older.m1_n[b];
        // Newest write wins so that write-then-read stays coherent
        assign rd_word[b*`LANE_W +: `LANE_W] =
            n1 ? newest.d1[b*`LANE_W +: `LANE_W] :
            n0 ? newest.d0[b*`LANE_W +: `LANE_W] :
            o1 ? older.d1[b*`LANE_W +: `LANE_W] :
            o0 ? older.d0[b*`LANE_W +: `LANE_W] :
            lane_mem_q[rd_addr];
    end

    // Output launch on half-cycle edges: data, enable, echo clocks, valid, termination
    logic [`DATA_W-1:0]       dq_q;
    logic                     oe_n_q;
    logic                     echo_q;
    logic                     read_valid_flag_q;
    logic                     odt_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dq_q   <= '0;
            oe_n_q <= 1'b1;
            echo_q <= 1'b0;
            read_valid_flag_q <= 1'b0;
            odt_q  <= 1'b1;
        end else if (half_edge) begin
            if (beat0_due || beat1_due) begin
                dq_q <= rd_word;
            end
            oe_n_q <= ~(beat0_due | beat1_due);
            echo_q <= k_rise;
            read_valid_flag_q <= pipe_q[idx_m2].valid;
            odt_q  <= ~odt_off_next;
        end
    end

    assign dq_o              = dq_q;
    assign dq_oe_n_o         = oe_n_q;
    assign echo_timing_pos_o = echo_q;
    assign echo_timing_neg_o = ~echo_q;
    assign read_valid_flag_o = read_valid_flag_q;
    assign odt_data_o        = odt_q;
    assign odt_clk_mask_o    = 1'b1;
    assign write_buf_ready_o = wbuf_ready;

    // Beat-0 address kept only so the burst order can be checked
    logic [`ADDR_W-1:0]       beat0_addr_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            beat0_addr_q <= '0;
        end else if (half_edge && beat0_due) begin
            beat0_addr_q <= rd_addr;
        end
    end

    // DLL reset and lock tracking; a long static clock counts as a stop
    logic [`KSTOP_W-1:0]      stop_cnt_q;
    logic [`LOCK_W-1:0]       lock_cnt_q;
    wire clk_static = (sync2_q.k == k_prev_q) & (sync2_q.k_n == kn_prev_q);
    wire stop_hit   = clk_static & (stop_cnt_q == `KSTOP_W'(`KSTOP_CYC - 1));
    wire dll_reset  = (sync2_q.dll_bypass_n & ~byp_prev_q) | stop_hit;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stop_cnt_q <= '0;
            lock_cnt_q <= '0;
        end else begin
            if (!clk_static) begin
                stop_cnt_q <= '0;
            end else if (stop_cnt_q != `KSTOP_W'(`KSTOP_CYC)) begin
                stop_cnt_q <= stop_cnt_q + `KSTOP_W'(1);
            end
            if (dll_reset) begin
                lock_cnt_q <= '0;
            end else if (k_rise && lock_cnt_q != `LOCK_CYC) begin
                lock_cnt_q <= lock_cnt_q + `LOCK_W'(1);
            end
        end
    end
    assign dll_locked_o = lock_cnt_q == `LOCK_CYC;

    // Impedance code walks one step per K cycle, forced final at the deadline
    logic [`ZQ_W-1:0]         zq_q;
    logic [`ZQ_CNT_W-1:0]     zq_cnt_q;
    wire [`ZQ_W-1:0] zq_tgt = sync2_q.impedance_ref_pin;
    wire zq_deadline = zq_cnt_q == (`ZQ_CYC - `ZQ_CNT_W'(1));
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            zq_q     <= `ZQ_MID;
            zq_cnt_q <= '0;
        end else if (k_rise) begin
            if (zq_cnt_q != `ZQ_CYC) begin
                zq_cnt_q <= zq_cnt_q + `ZQ_CNT_W'(1);
            end
            if (zq_deadline || zq_q == zq_tgt) begin
                zq_q <= zq_tgt;
            end else if (zq_q < zq_tgt) begin
                zq_q <= zq_q + `ZQ_W'(1);
            end else begin
                zq_q <= zq_q - `ZQ_W'(1);
            end
        end
    end
    assign impedance_code_o = zq_q;
    assign impedance_done_o = zq_cnt_q == `ZQ_CYC;

    a_first_beat_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        half_edge && beat0_due |=> !dq_oe_n_o && dq_o == $past(rd_word))
        else $error("first read beat not driven on its edge");
    a_second_beat_addr: assert property (@(posedge clk_i) disable iff (rst_i)
        half_edge && beat1_due && !beat0_due |-> rd_addr == beat0_addr_q + `ADDR_W'(1))
        else $error("second beat not at address plus one");
    a_valid_lead: assert property (@(posedge clk_i) disable iff (rst_i)
        half_edge && beat0_due |-> read_valid_flag_o)
        else $error("valid flag did not lead read data");
    a_valid_fall: assert property (@(posedge clk_i) disable iff (rst_i)
        half_edge && beat1_due && !beat0_due |-> !read_valid_flag_o)
        else $error("valid flag still high at final beat");
    a_read_no_commit: assert property (@(posedge clk_i) disable iff (rst_i)
        k_rise && sync2_q.rw |-> !wbuf_pop)
        else $error("array written while direction high");
    a_odt_when_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        !dq_oe_n_o |-> !odt_data_o)
        else $error("termination on while driving");
    a_clk_odt_on: assert property (@(posedge clk_i) disable iff (rst_i)
        odt_clk_mask_o)
        else $error("clock termination dropped");
    a_echo_pair: assert property (@(posedge clk_i) disable iff (rst_i)
        k_rise |=> echo_timing_pos_o && !echo_timing_neg_o)
        else $error("echo clocks not following K");
    a_bypass_latency: assert property (@(posedge clk_i) disable iff (rst_i)
        !sync2_q.dll_bypass_n |=> lat_q == `LAT_BYP)
        else $error("bypass latency not selected");
    a_dll_unlock: assert property (@(posedge clk_i) disable iff (rst_i)
        dll_reset |=> !dll_locked_o ##1 !dll_locked_o)
        else $error("lock kept after DLL reset");
    a_commit_third: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_cmd && wbuf_full |=> wcnt_q == 2'h1)
        else $error("third write did not commit oldest");
    a_zq_final: assert property (@(posedge clk_i) disable iff (rst_i)
        impedance_done_o |-> impedance_code_o == $past(zq_tgt, 1) || $changed(zq_tgt))
        else $error("impedance not final after deadline");

endmodule : burst2_common_io_sram

/* File: verif/sram_ctl_model.sv */
// Behavioural memory controller driving the burst-of-two SRAM device pins
`timescale 1ns/1ps
`include "burst2_sram_regs.svh"
module sram_ctl_model (
    input  wire logic                 clk_i,
    output logic                      k_o,
    output logic                      k_n_o,
    output logic                      load_strobe_n_o,
    output logic                      rw_o,
    output logic      [`ADDR_W-1:0]   addr_o,
    output logic      [`DATA_W-1:0]   dq_o,
    output logic      [`LANES-1:0]    byte_write_mask_n_o
);
    logic                drive_q;
    logic [`DATA_W-1:0]  data_q;
    logic [`DATA_W-1:0]  idle_q;

    // Free-running link clock, offset so it never lines up with clk_i
    initial begin
        k_o = 1'b0;
        #3;
        forever #80 k_o = ~k_o;
    end
    assign k_n_o = ~k_o;

    initial begin
        load_strobe_n_o     = 1'b1;
        rw_o                = 1'b1;
        addr_o              = '0;
        byte_write_mask_n_o = '1;
        drive_q             = 1'b0;
        data_q              = '0;
        idle_q              = 36'h5A5A5A5A5;
    end

    // Released bus keeps changing so a stale value cannot pass for data
    always @(posedge clk_i) idle_q <= ~idle_q;
    assign dq_o = drive_q ? data_q : idle_q;

    // Changes land mid-half so both edges see settled pins
    task automatic mid(input logic rise);
        if (rise) @(posedge k_o);
        else @(posedge k_n_o);
        repeat (4) @(posedge clk_i);
    endtask : mid

    task automatic issue(input logic rd, input logic [`ADDR_W-1:0] a);
        mid(1'b0);
        load_strobe_n_o <= 1'b0;
        rw_o            <= rd;
        addr_o          <= a;
        mid(1'b1);
        load_strobe_n_o <= 1'b1;
        rw_o            <= ~rd;
        addr_o          <= ~a;
    endtask : issue

    task automatic write_burst(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d0,
                               input logic [`DATA_W-1:0] d1, input logic [`LANES-1:0] m0,
                               input logic [`LANES-1:0] m1);
        issue(1'b0, a);
        data_q              <= d0;
        byte_write_mask_n_o <= m0;
        drive_q             <= 1'b1;
        mid(1'b1);
        data_q              <= d1;
        byte_write_mask_n_o <= m1;
        mid(1'b0);
        drive_q             <= 1'b0;
        byte_write_mask_n_o <= ~m1;
    endtask : write_burst
endmodule : sram_ctl_model

/* File: verif/burst2_common_io_sram_bench.sv */
// Self-checking bench for the burst-of-two common-I/O SRAM device logic
`timescale 1ns/1ps
`include "burst2_sram_regs.svh"
module burst2_common_io_sram_bench;
    logic                clk;
    logic                rst;
    logic                dll_bypass_n;
    logic [`ZQ_W-1:0]    zq_ref;
    logic                k, k_n, load_strobe_n, rw, dq_oe_n, echo_pos, echo_neg;
    logic                rd_valid, odt_data, odt_clk_mask, dll_locked, imp_done, wb_ready;
    logic [`ADDR_W-1:0]  addr;
    logic [`DATA_W-1:0]  ctl_dq, dev_dq, dq_bus;
    logic [`LANES-1:0]   mask_n;
    logic [`ZQ_W-1:0]    imp_code;
    logic [`DATA_W-1:0]  exp_mem [logic [`ADDR_W-1:0]];
    logic [`ADDR_W-1:0]  pool [4] = '{19'h7FFFF, 19'h00010, 19'h00011, 19'h2A5C3};
    int                  seed, error_cnt, checks_done, cyc, krise, nbuf;

    assign dq_bus = dq_oe_n ? ctl_dq : dev_dq;

    sram_ctl_model sram_ctl_model_i (.clk_i(clk), .k_o(k), .k_n_o(k_n),
        .load_strobe_n_o(load_strobe_n), .rw_o(rw), .addr_o(addr), .dq_o(ctl_dq),
        .byte_write_mask_n_o(mask_n));

    burst2_common_io_sram burst2_common_io_sram_i (.clk_i(clk), .rst_i(rst), .k_i(k),
        .k_n_i(k_n), .load_strobe_n_i(load_strobe_n), .rw_i(rw), .addr_i(addr),
        .dq_i(dq_bus), .dq_o(dev_dq), .dq_oe_n_o(dq_oe_n), .byte_write_mask_n_i(mask_n),
        .dll_bypass_n_i(dll_bypass_n), .impedance_ref_pin_i(zq_ref),
        .echo_timing_pos_o(echo_pos), .echo_timing_neg_o(echo_neg),
        .read_valid_flag_o(rd_valid), .odt_data_o(odt_data), .odt_clk_mask_o(odt_clk_mask),
        .dll_locked_o(dll_locked), .impedance_code_o(imp_code),
        .impedance_done_o(imp_done), .write_buf_ready_o(wb_ready));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge k) krise++;

    // Ceiling leaves ample room over the roughly 17000 cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            $display("BAD %0t run did not finish", $time);
            final_report();
        end
    end

    task automatic final_report;
        if (error_cnt == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report

    task automatic cmp_bit(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask : cmp_bit

    task automatic cmp_word(input logic [`DATA_W-1:0] got, input logic [`DATA_W-1:0] exp,
                            input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp_word

    function automatic logic [`DATA_W-1:0] merge(input logic [`DATA_W-1:0] old,
            input logic [`DATA_W-1:0] nw, input logic [`LANES-1:0] m_n);
        merge = old;
        for (int b = 0; b < `LANES; b++)
            if (!m_n[b]) merge[b*`LANE_W +: `LANE_W] = nw[b*`LANE_W +: `LANE_W];
    endfunction : merge

    task automatic do_write(input logic [`ADDR_W-1:0] a, input logic full);
        logic [`DATA_W-1:0] d0, d1;
        logic [`LANES-1:0]  m0, m1;
        logic [`ADDR_W-1:0] a1;
        d0 = `DATA_W'({$random(seed), $random(seed)});
        d1 = `DATA_W'({$random(seed), $random(seed)});
        m0 = full ? '0 : `LANES'($random(seed));
        m1 = full ? '0 : `LANES'($random(seed));
        a1 = a + 1'b1;
        cmp_bit(wb_ready, logic'(nbuf < 2), "buffer ready");
        sram_ctl_model_i.write_burst(a, d0, d1, m0, m1);
        // Two bursts wait in the buffer until a third write commits one
        if (nbuf < 2) nbuf++;
        exp_mem[a]  = merge(exp_mem[a], d0, m0);
        exp_mem[a1] = merge(exp_mem[a1], d1, m1);
    endtask : do_write

    // Walks every half-edge of one read; latency follows the bypass input
    task automatic read_check(input logic [`ADDR_W-1:0] a);
        int                 lat;
        logic [`ADDR_W-1:0] a1;
        a1  = a + 1'b1;
        sram_ctl_model_i.issue(1'b1, a);
        // Bypass level has settled by the time the command is taken
        lat = dll_bypass_n ? 5 : 2;
        for (int he = 1; he <= lat + 3; he++) begin
            if (he % 2) @(posedge k_n);
            else @(posedge k);
            repeat (5) @(posedge clk);
            cmp_bit(echo_pos, logic'(he % 2 == 0), "echo pos");
            cmp_bit(echo_neg, logic'(he % 2 == 1), "echo neg");
            if (he == lat - 1) begin
                cmp_bit(rd_valid, 1'b1, "valid early");
                cmp_bit(odt_data, 1'b0, "odt off");
            end
            if (he == lat) begin
                cmp_bit(dq_oe_n, 1'b0, "drive beat0");
                cmp_word(dev_dq, exp_mem[a], "beat0");
                cmp_bit(rd_valid, 1'b0, "valid low");
                cmp_bit(odt_data, 1'b0, "odt driving");
            end
            if (he == lat + 1) begin
                cmp_bit(dq_oe_n, 1'b0, "drive beat1");
                cmp_word(dev_dq, exp_mem[a1], "beat1");
            end
            if (he == lat + 2) begin
                cmp_bit(dq_oe_n, 1'b1, "release");
                cmp_bit(odt_data, 1'b0, "odt late");
            end
            if (he == lat + 3) cmp_bit(odt_data, 1'b1, "odt on");
        end
    endtask : read_check

    initial begin
        logic [31:0]        r;
        logic [`ADDR_W-1:0] a;
        seed         = 81;
        rst          = 1'b1;
        dll_bypass_n = 1'b0;
        zq_ref       = `ZQ_W'($random(seed));
        foreach (pool[i]) begin
            exp_mem[pool[i]]        = '0;
            exp_mem[pool[i] + 1'b1] = '0;
        end
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        cmp_word({30'h0, imp_code}, {30'h0, `ZQ_MID}, "zq start");
        cmp_bit(imp_done, 1'b0, "zq busy");
        cmp_bit(odt_data, 1'b1, "odt idle");
        cmp_bit(odt_clk_mask, 1'b1, "odt clk");
        cmp_bit(dll_locked, 1'b0, "lock early");
        @(posedge clk);
        dll_bypass_n <= 1'b1;
        foreach (pool[i]) do_write(pool[i], 1'b1);
        for (int i = 0; i < 44; i++) begin
            r = $random(seed);
            a = (i < 8) ? pool[0] : pool[r[2:1]];
            if (i == 24) dll_bypass_n <= 1'b0;
            if (i == 34) dll_bypass_n <= 1'b1;
            if (r[0] || i == 3 || i == 7) read_check(a);
            else do_write(a, 1'b0);
        end
        while (krise < 1040) @(posedge clk);
        cmp_bit(imp_done, 1'b1, "zq done");
        cmp_word({30'h0, imp_code}, {30'h0, zq_ref}, "zq final");
        final_report();
    end
endmodule : burst2_common_io_sram_bench
